// ===== common/trig_pkg.sv
// Package: register map, field layout, reset values and timing constants for the start trigger block.
// Assumes a 50 MHz system clock and a 32-bit classic Wishbone register bus.
package trig_pkg;
	// Clock and time base
	localparam int unsigned CLK_HZ        = 50000000;
	localparam int unsigned US_NS         = 1000;
	localparam int unsigned CLK_NS        = 20;
	localparam int unsigned US_CYCLES     = US_NS / CLK_NS;   // Cycles per microsecond
	localparam int unsigned US_CNT_W      = 6;
	localparam logic [US_CNT_W-1:0] US_LAST = US_CNT_W'(US_CYCLES - 1);

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS      = 8'h00;
	localparam logic [7:0] EXP_RAW_OFS   = 8'h04;
	localparam logic [7:0] EXP_BASE_OFS  = 8'h08;
	localparam logic [7:0] DELAY_OFS     = 8'h0c;
	localparam logic [7:0] STATUS_OFS    = 8'h10;

	// Control field positions
	localparam int CTRL_MODE_ON_BIT  = 0;
	localparam int CTRL_SRC_BIT      = 1;
	localparam int CTRL_EDGE_BIT     = 2;
	localparam int CTRL_EXPMODE_BIT  = 3;
	localparam int CTRL_PACING_BIT   = 4;
	localparam int CTRL_SW_TRIG_BIT  = 5;

	// Field widths and reset values
	localparam int RAW_W   = 12;
	localparam int BASE_W  = 24;
	localparam int DELAY_W = 24;
	localparam logic [RAW_W-1:0]   EXP_RAW_MIN   = 12'h001;
	localparam logic [RAW_W-1:0]   EXP_RAW_MAX   = 12'hfff;
	localparam logic [RAW_W-1:0]   EXP_RAW_RST   = 12'h064;
	localparam logic [BASE_W-1:0]  EXP_BASE_RST  = 24'h000014;  // 20 us
	localparam logic [DELAY_W-1:0] DELAY_RST     = 24'h000000;
	localparam logic [5:0]         CTRL_RST      = 6'h00;

	// Trigger source, edge and exposure mode encodings
	localparam logic SRC_LINE1    = 1'b1;
	localparam logic EDGE_RISING  = 1'b0;
	localparam logic EXP_TIMED    = 1'b0;
	localparam logic EXP_WIDTH    = 1'b1;

	typedef enum logic [2:0]
	{
		ST_WAIT    = 3'b000,
		ST_DELAY   = 3'b001,
		ST_TIMED   = 3'b010,
		ST_WIDTH   = 3'b011,
		ST_STRETCH = 3'b100
	} acq_state_type;
endpackage

// ===== common/us_tick_if.sv
// Interface: microsecond tick from the divider to the trigger core.
// Assumes both ends share clk_i.
interface us_tick_if;
	logic tick;
	modport source (output tick);
	modport sink   (input tick);
endinterface

// ===== core/us_divider.sv
// Microsecond tick divider.
// Assumes the 50 MHz system clock and synchronous active-high reset.
module us_divider
	import trig_pkg::*;
(
	input  wire logic clk_i,   // System clock
	input  wire logic rst_i,   // Synchronous reset
	us_tick_if.source tick_o   // One-cycle pulse per microsecond
);
	logic [US_CNT_W-1:0] cnt_reg;
	logic                tick_reg;

	// Count cycles, pulse on the last one
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_reg  <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			cnt_reg  <= (cnt_reg == US_LAST) ? '0 : cnt_reg + 1'b1;
			tick_reg <= (cnt_reg == US_LAST);
		end
	end

	assign tick_o.tick = tick_reg;
endmodule // us_divider

// ===== core/start_trigger.sv
// Start trigger and exposure control with a Wishbone register file.
// Assumes one 50 MHz clock, synchronous reset, and readout_busy_i from the sensor side.
// Behaviour
// [R1] Mode on, source line 1: line triggers
// [R2] Edge select chooses rising or falling
// [R3] Waiting status: each selected edge starts frame
// [R4] Leave waiting at exposure, return when ready; with a start delay set, the code leaves waiting at the edge, before the delay
// [R5] Edges outside waiting status are discarded
// [R6] Source keeps trigger rate within limits
// [R7] Two exposure modes: timed and width
// [R8] Timed exposure lasts raw times base
// [R9] Timed mode ignores edges during exposure
// [R10] Width mode rising: expose while high
// [R11] Width mode falling: expose while low
// [R12] Width mode still times trigger-ready output
// [R13] Software sets exposure to shortest width
// [R14] Width mode stretches exposure until readout ends
// [R15] Otherwise exposure equals active pulse time
// [R16] Programmable microsecond delay before trigger acts
// [R17] Delay unused when mode off or software
// [R18] Software disables internal rate pacing; the code takes internal_rate_pacing_enable_o from the pacing bit alone
// [R19] Synchronise input, count microsecond ticks
// [R20] Exposure is raw times base, raw 1..4095
// [R21] Exposure base resets to twenty microseconds
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
module start_trigger
	import trig_pkg::*;
(
	input  wire logic        clk_i,           // System clock
	input  wire logic        rst_i,           // Synchronous reset
	input  wire logic        external_start_trigger_i, // Input line 1
	input  wire logic        readout_busy_i,  // Previous frame reading out
	input  wire logic [31:0] adr_i,           // Wishbone address
	input  wire logic [31:0] dat_i,           // Wishbone write data
	input  wire logic [3:0]  sel_i,           // Wishbone byte selects
	input  wire logic        we_i,            // Wishbone write enable
	input  wire logic        cyc_i,           // Wishbone cycle
	input  wire logic        stb_i,           // Wishbone strobe
	output logic      [31:0] dat_o,           // Wishbone read data
	output logic             ack_o,           // Wishbone acknowledge
	output logic             exposing_o,      // Exposure active
	output logic             frame_start_o,   // Pulse at exposure start
	output logic             trigger_ready_o, // Waiting for start trigger
	output logic             internal_rate_pacing_enable_o // Rate pacing setting
);
	us_tick_if tick_bus ();
	us_divider u_div (.clk_i(clk_i), .rst_i(rst_i), .tick_o(tick_bus));

	logic [5:0]         ctrl_reg;
	logic [RAW_W-1:0]   raw_reg;
	logic [BASE_W-1:0]  base_reg;
	logic [DELAY_W-1:0] start_delay_us_reg;
	logic               sync1_reg, sync2_reg, prev_reg;
	acq_state_type      state_reg, state_next;
	logic [35:0]        cnt_reg, cnt_next;
	logic               ack_reg, exp_reg, fs_reg, rdy_reg;
	logic [31:0]        dat_reg;

	// Bus decode
	wire bus_req  = cyc_i & stb_i & ~ack_reg;
	// Writes land at the edge where the master samples ack
	wire bus_done = cyc_i & stb_i & ack_reg;
	wire bus_wr   = bus_done & we_i & (&sel_i);
	wire hit_ctrl = (adr_i[7:0] == CTRL_OFS);
	wire hit_raw  = (adr_i[7:0] == EXP_RAW_OFS);
	wire hit_base = (adr_i[7:0] == EXP_BASE_OFS);
	wire hit_dly  = (adr_i[7:0] == DELAY_OFS);
	wire hit_stat = (adr_i[7:0] == STATUS_OFS);
	wire [RAW_W-1:0] raw_wr = (dat_i[RAW_W-1:0] == '0) ? EXP_RAW_MIN : dat_i[RAW_W-1:0]; // R20

	// Control fields
	wire hw_on   = ctrl_reg[CTRL_MODE_ON_BIT] & (ctrl_reg[CTRL_SRC_BIT] == SRC_LINE1); // R1
	wire sw_on   = ctrl_reg[CTRL_MODE_ON_BIT] & (ctrl_reg[CTRL_SRC_BIT] != SRC_LINE1);
	wire edge_f  = ctrl_reg[CTRL_EDGE_BIT];
	wire width_m = (ctrl_reg[CTRL_EXPMODE_BIT] == EXP_WIDTH); // R7
	wire sw_trig = bus_wr & hit_ctrl & dat_i[CTRL_SW_TRIG_BIT];

	// Edge detection on the synchronised line
	wire line_act  = edge_f ? ~sync2_reg : sync2_reg;                  // R2 R11
	wire prev_act  = edge_f ? ~prev_reg : prev_reg;
	wire hw_edge   = hw_on & line_act & ~prev_act;                     // R2
	wire line_end  = ~line_act;                                        // R10 R11
	wire waiting   = (state_reg == ST_WAIT) & (cnt_reg == '0);         // R12
	wire no_delay  = (start_delay_us_reg == '0);
	wire [35:0] exp_cycles = 36'(raw_reg) * 36'(base_reg);             // R20

	// Input synchroniser, first stage read only by second
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg  <= 1'b0;
		end
		else
		begin
			sync1_reg <= external_start_trigger_i; // R19
			sync2_reg <= sync1_reg;                // R19
			prev_reg  <= sync2_reg;
		end
	end

	// Acquisition state machine
	always_comb
	begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			ST_WAIT:
			begin
				if (~waiting)
				begin
					if (tick_bus.tick)
						cnt_next = cnt_reg - 36'h1;  // R12
				end
				else if (sw_trig & sw_on)            // R17
				begin
					state_next = ST_TIMED;
					cnt_next   = exp_cycles;
				end
				else if (hw_edge & ~no_delay)        // R3 R16
				begin
					state_next = ST_DELAY;
					cnt_next   = 36'(start_delay_us_reg);
				end
				else if (hw_edge)                    // R3 R8 R10
				begin
					state_next = width_m ? ST_WIDTH : ST_TIMED;
					cnt_next   = exp_cycles;
				end
			end
			ST_DELAY:
			begin
				if (tick_bus.tick)
				begin
					if (cnt_reg == 36'h1)            // R16 R19
					begin
						state_next = width_m ? ST_WIDTH : ST_TIMED;
						cnt_next   = exp_cycles;
					end
					else
						cnt_next = cnt_reg - 36'h1;
				end
			end
			ST_TIMED:
			begin
				if (tick_bus.tick)
				begin
					if (cnt_reg <= 36'h1)            // R8 R9
					begin
						state_next = ST_WAIT;
						cnt_next   = '0;
					end
					else
						cnt_next = cnt_reg - 36'h1;
				end
			end
			ST_WIDTH:
			begin
				if (tick_bus.tick & (cnt_reg != '0))
					cnt_next = cnt_reg - 36'h1;      // R12
				if (line_end)
					state_next = readout_busy_i ? ST_STRETCH : ST_WAIT; // R14 R15
			end
			ST_STRETCH:
			begin
				if (~readout_busy_i)
					state_next = ST_WAIT;            // R14 R4
				if (tick_bus.tick & (cnt_reg != '0))
					cnt_next = cnt_reg - 36'h1;      // R12
			end
			default:
			begin
				state_next = ST_WAIT;
				cnt_next   = '0;
			end
		endcase
	end

	// State and microsecond counter; the counter also holds off ready after short pulses
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg  <= ST_WAIT;
			cnt_reg    <= '0;
		end
		else
		begin
			state_reg  <= state_next; // R4 R5
			cnt_reg    <= cnt_next;
		end
	end

	// Outputs from flops
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			exp_reg <= 1'b0;
			fs_reg  <= 1'b0;
			rdy_reg <= 1'b0;
		end
		else
		begin
			exp_reg <= (state_next == ST_TIMED) | (state_next == ST_WIDTH) | (state_next == ST_STRETCH);
			fs_reg  <= ~waiting & (state_reg != ST_DELAY) ? 1'b0
			           : ((state_next == ST_TIMED) | (state_next == ST_WIDTH)) & (state_reg != state_next);
			rdy_reg <= (state_next == ST_WAIT) & (cnt_next == '0); // R4 R12
		end
	end

	// Register writes
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_reg           <= CTRL_RST;
			raw_reg            <= EXP_RAW_RST;
			base_reg           <= EXP_BASE_RST; // R21
			start_delay_us_reg <= DELAY_RST;
		end
		else if (bus_wr)
		begin
			if (hit_ctrl)
				ctrl_reg <= {1'b0, dat_i[4:0]};
			if (hit_raw)
				raw_reg <= raw_wr; // R20
			if (hit_base)
				base_reg <= (dat_i[BASE_W-1:0] == '0) ? EXP_BASE_RST : dat_i[BASE_W-1:0];
			if (hit_dly)
				start_delay_us_reg <= dat_i[DELAY_W-1:0];
		end
	end

	// Read mux and acknowledge, one wait state
	wire [31:0] rd_mux = hit_ctrl ? {26'h0, ctrl_reg} :
	                     hit_raw  ? {20'h0, raw_reg} :
	                     hit_base ? {8'h0, base_reg} :
	                     hit_dly  ? {8'h0, start_delay_us_reg} :
	                     hit_stat ? {27'h0, readout_busy_i, state_reg, waiting} : 32'h0;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0;
		end
		else
		begin
			ack_reg <= bus_req;
			dat_reg <= bus_req ? rd_mux : 32'h0;
		end
	end

	assign dat_o            = dat_reg;
	assign ack_o            = ack_reg;
	assign exposing_o       = exp_reg;
	assign frame_start_o    = fs_reg;
	assign trigger_ready_o  = rdy_reg;
	assign internal_rate_pacing_enable_o = ctrl_reg[CTRL_PACING_BIT];

	// Assertions
	a_edge_ignored: assert property (@(posedge clk_i) disable iff (rst_i) // R5
		!waiting && (state_reg != ST_DELAY) && hw_edge |=> !frame_start_o) else $error("edge taken while busy");
	a_timed_stays: assert property (@(posedge clk_i) disable iff (rst_i) // R9
		(state_reg == ST_TIMED) && hw_edge |=> (state_reg == ST_TIMED) || (state_reg == ST_WAIT))
		else $error("timed exposure restarted");
	a_edge_starts: assert property (@(posedge clk_i) disable iff (rst_i) // R3
		waiting && hw_edge && no_delay |=> exposing_o) else $error("edge did not start exposure");
	a_ready_leaves: assert property (@(posedge clk_i) disable iff (rst_i) // R4
		exposing_o |-> !trigger_ready_o) else $error("ready during exposure");
	a_stretch_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R14
		(state_reg == ST_WIDTH) && line_end && readout_busy_i |=> (state_reg == ST_STRETCH))
		else $error("exposure not stretched");
	a_width_end: assert property (@(posedge clk_i) disable iff (rst_i) // R15
		(state_reg == ST_WIDTH) && line_end && !readout_busy_i |=> !exposing_o)
		else $error("width exposure not ended");
	a_width_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R10 R11
		(state_reg == ST_WIDTH) && !line_end |=> exposing_o)
		else $error("width exposure dropped early");
	a_stretch_ends: assert property (@(posedge clk_i) disable iff (rst_i) // R14
		(state_reg == ST_STRETCH) && !readout_busy_i |=> (state_reg == ST_WAIT))
		else $error("stretch outlived readout");
	a_ready_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R12
		(state_reg == ST_WAIT) && (cnt_reg > 36'h1) |=> !trigger_ready_o)
		else $error("ready before minimum exposure");
	a_timed_runs: assert property (@(posedge clk_i) disable iff (rst_i) // R8
		(state_reg == ST_TIMED) && !tick_bus.tick |=> (state_reg == ST_TIMED))
		else $error("timed exposure cut short");
	a_frame_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // R3
		frame_start_o |=> !frame_start_o) else $error("frame start longer than one cycle");
	a_base_set: assert property (@(posedge clk_i) disable iff (rst_i) // R20
		base_reg != '0) else $error("exposure base zero");
	a_delay_used: assert property (@(posedge clk_i) disable iff (rst_i) // R16
		waiting && hw_edge && !no_delay |=> (state_reg == ST_DELAY)) else $error("delay skipped");
	a_sw_nodelay: assert property (@(posedge clk_i) disable iff (rst_i) // R17
		waiting && sw_trig && sw_on |=> (state_reg == ST_TIMED)) else $error("software trigger delayed");
	a_raw_range: assert property (@(posedge clk_i) disable iff (rst_i) // R20
		raw_reg >= EXP_RAW_MIN) else $error("raw exposure zero");
	a_mode_off: assert property (@(posedge clk_i) disable iff (rst_i) // R1
		!ctrl_reg[CTRL_MODE_ON_BIT] |-> !hw_edge) else $error("edge seen with mode off");
	c_timed: cover property (@(posedge clk_i) disable iff (rst_i) (state_reg == ST_TIMED) ##1 (state_reg == ST_WAIT));
	c_stretch: cover property (@(posedge clk_i) disable iff (rst_i) (state_reg == ST_STRETCH));
	c_delay: cover property (@(posedge clk_i) disable iff (rst_i) (state_reg == ST_DELAY) ##1 (state_reg == ST_WIDTH));
	c_ready_hold: cover property (@(posedge clk_i) disable iff (rst_i) (state_reg == ST_WAIT) && !waiting);
	c_sw: cover property (@(posedge clk_i) disable iff (rst_i) sw_trig && sw_on && waiting);
endmodule // start_trigger

// ===== dv/trig_source.sv
// Model of the external trigger source driving the trigger line.
// Assumes the bench asks for one pulse at a time, spaced by the bench.
module trig_source
(
	input  wire logic        clk_i,  // System clock
	input  wire logic        fire_i, // Start one pulse
	input  wire logic [15:0] len_i,  // Pulse length in cycles
	input  wire logic        idle_i, // Inactive line level
	output logic             line_o  // Trigger line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] left_reg = 16'h0000;

	// Active level is the inverse of idle; length counted in cycles
	always_ff @(posedge clk_i)
	begin
		if (fire_i)
			left_reg <= len_i;
		else if (left_reg != 16'h0000)
			left_reg <= left_reg - 16'h0001;
	end
	assign line_o = idle_i ^ (left_reg != 16'h0000);
endmodule // trig_source

// ===== dv/hw_acq_start_trigger_exposure_test.sv
// Self-checking bench for the start trigger and exposure block.
// Assumes trig_pkg, the trigger source model and a 50 MHz clock.
module hw_acq_start_trigger_exposure_test;
	timeunit 1ns;
	timeprecision 1ps;
	import trig_pkg::*;
	logic clk_i = 0, rst_i = 1, busy = 0, we = 0, cyc = 0, stb = 0, fire = 0, idle = 0;
	logic [31:0] adr = 0, wdat = 0, dat_o, q;
	logic [15:0] len = 0;
	logic [3:0]  sel = 0;
	logic        line, ack_o, exp_o, fs_o, rdy_o, pace;
	int          error_cnt = 0, checks_done = 0, cyc_cnt = 0, fs_cnt = 0, exp_cnt = 0, f0, e0, n;

	always #10 clk_i = ~clk_i;
	// Pulse and exposure counters, plus hang guard
	always @(posedge clk_i)
	begin
		cyc_cnt++;
		if (fs_o === 1'b1) fs_cnt++;
		if (exp_o === 1'b1) exp_cnt++;
		if (cyc_cnt == 30000) begin error_cnt++; wrap_up(); end
	end

	start_trigger dut_u (.clk_i(clk_i), .rst_i(rst_i), .external_start_trigger_i(line),
		.readout_busy_i(busy), .adr_i(adr), .dat_i(wdat), .sel_i(sel), .we_i(we), .cyc_i(cyc),
		.stb_i(stb), .dat_o(dat_o), .ack_o(ack_o), .exposing_o(exp_o), .frame_start_o(fs_o),
		.trigger_ready_o(rdy_o), .internal_rate_pacing_enable_o(pace));
	trig_source src_u (.clk_i(clk_i), .fire_i(fire), .len_i(len), .idle_i(idle), .line_o(line));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] expv);
		checks_done++;
		if (seen !== expv)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, expv, seen);
		end
	endtask
	// One classic Wishbone cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1; stb <= 1; we <= w; adr <= {24'h0, a}; wdat <= d; sel <= 4'hf;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc <= 0; stb <= 0; we <= 0;
		@(posedge clk_i);
	endtask
	task automatic pulse(input int l);
		fire <= 1; len <= l[15:0];
		@(posedge clk_i);
		fire <= 0;
	endtask
	// Mode off, then move the idle level, so no stray edge reaches the block
	task automatic quiet(input logic fall);
		wb(1, CTRL_OFS, 0);
		idle <= fall;
		repeat (10) @(posedge clk_i);
	endtask
	task automatic mark();
		f0 = fs_cnt; e0 = exp_cnt;
	endtask
	task automatic t_regs();
		wb(0, EXP_BASE_OFS, 0); chk("base", q, 32'h14);
		wb(0, EXP_RAW_OFS, 0); chk("raw", q, 32'h64);
		wb(1, EXP_RAW_OFS, 0); wb(0, EXP_RAW_OFS, 0); chk("raw0", q, 32'h1);
		wb(0, 8'h14, 0); chk("unmapped", q, 32'h0);
		wb(1, CTRL_OFS, 32'h10); wb(0, CTRL_OFS, 0); chk("ctrl", q, 32'h10);
		chk("pacing", pace, 1);
		wb(0, STATUS_OFS, 0); chk("status", q, 32'h1);
		wb(1, CTRL_OFS, 0); chk("pacing_off", pace, 0);
		chk("ready", rdy_o, 1);
	endtask
	// Timed exposure with a second edge inside it
	task automatic t_timed(input logic fall);
		quiet(fall);
		wb(1, EXP_RAW_OFS, 4); wb(1, EXP_BASE_OFS, 1); wb(1, DELAY_OFS, 0);
		wb(1, CTRL_OFS, {29'h0, fall, 2'h3}); mark();
		pulse(20); repeat (60) @(posedge clk_i); pulse(20);
		repeat (300) @(posedge clk_i);
		chk("fs", fs_cnt - f0, 1);
		chk("exp", (exp_cnt - e0 >= 151 && exp_cnt - e0 <= 202), 1);
		chk("ready", rdy_o, 1);
	endtask
	task automatic t_width(input logic fall, input int bz);
		quiet(fall);
		wb(1, EXP_RAW_OFS, 4);
		wb(1, CTRL_OFS, {28'h0, 1'b1, fall, 2'h3}); mark();
		busy <= (bz != 0);
		pulse(bz != 0 ? 50 : 300);
		repeat (bz != 0 ? 400 : 10) @(posedge clk_i);
		busy <= 0;
		repeat (400) @(posedge clk_i);
		n = exp_cnt - e0;
		if (bz != 0) chk("stretch", (n >= 385 && n <= 402), 1);
		else chk("width", (n >= 298 && n <= 302), 1);
		chk("fs_w", fs_cnt - f0, 1);
	endtask
	// Width pulse shorter than the programmed minimum: ready held off
	task automatic t_min();
		quiet(0);
		wb(1, EXP_RAW_OFS, 8);
		wb(1, CTRL_OFS, 32'hb); mark();
		pulse(50);
		repeat (100) @(posedge clk_i);
		chk("min_exp", exp_o, 0);
		chk("min_hold", rdy_o, 0);
		pulse(50);
		repeat (400) @(posedge clk_i);
		chk("min_rdy", rdy_o, 1);
		chk("min_fs", fs_cnt - f0, 1);
	endtask
	// Delay before the trigger acts, software start without it, then line ignored with mode off
	task automatic t_delay();
		quiet(0);
		wb(1, EXP_RAW_OFS, 1); wb(1, DELAY_OFS, 3);
		wb(1, CTRL_OFS, 3); mark(); n = 0;
		pulse(20);
		while (fs_cnt == f0 && n < 400) begin @(posedge clk_i); n++; end
		chk("delay", (n >= 104 && n <= 156), 1);
		repeat (200) @(posedge clk_i);
		wb(1, CTRL_OFS, 1); mark();
		wb(1, CTRL_OFS, 32'h21);
		repeat (2) @(posedge clk_i);
		chk("sw_nodelay", fs_cnt - f0, 1);
		repeat (100) @(posedge clk_i);
		wb(1, CTRL_OFS, 2); mark();
		pulse(20); repeat (300) @(posedge clk_i);
		chk("off", fs_cnt - f0, 0);
	endtask
	task automatic wrap_up();
		if (error_cnt == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		@(posedge clk_i);
		t_regs();
		t_timed(0);
		t_timed(1);
		t_width(0, 0);
		t_width(1, 0);
		t_width(0, 1);
		t_min();
		t_delay();
		wrap_up();
	end
endmodule // hw_acq_start_trigger_exposure_test
